/* File: rtl/etd_pkg.sv */
// Constants shared by the transmit DMA, MAC control and receive filter logic.
// Assumes a 25 MHz system clock and 32-bit host memory words.
package etd_pkg;
  // Register byte offsets on the APB slave.
  localparam logic [7:0] ETD_OFS_HEAD    = 8'h00;
  localparam logic [7:0] ETD_OFS_POLL    = 8'h04;
  localparam logic [7:0] ETD_OFS_MACCTL  = 8'h08;
  localparam logic [7:0] ETD_OFS_RXCFG   = 8'h0c;
  localparam logic [7:0] ETD_OFS_NODE_LO = 8'h10;
  localparam logic [7:0] ETD_OFS_NODE_HI = 8'h14;
  localparam logic [7:0] ETD_OFS_HASH_LO = 8'h18;
  localparam logic [7:0] ETD_OFS_HASH_HI = 8'h1c;
  localparam logic [7:0] ETD_OFS_RELTH   = 8'h20;
  localparam logic [7:0] ETD_OFS_STATUS  = 8'h24;
  localparam logic [7:0] ETD_OFS_OCC     = 8'h28;
  // Control register bits.
  localparam int ETD_MC_DUPLEX = 0;
  localparam int ETD_MC_PAUSE  = 1;
  localparam int ETD_MC_TXEN   = 2;
  localparam int ETD_MC_GO     = 3;
  // Receive match configuration bits.
  localparam int ETD_RX_UNI  = 0;
  localparam int ETD_RX_HASH = 1;
  localparam int ETD_RX_IPG  = 2;
  // Status bits, write one to clear for the sticky ones.
  localparam int ETD_ST_OVR  = 0;
  localparam int ETD_ST_LATE = 1;
  localparam int ETD_ST_DONE = 2;
  localparam int ETD_ST_BUSY = 3;
  localparam int ETD_ST_PAUSE = 4;
  // Descriptor layout, byte offsets from the descriptor base.
  localparam logic [31:0] ETD_D_LINK  = 32'h0000_0000;
  localparam logic [31:0] ETD_D_CTRL  = 32'h0000_0004;
  localparam logic [31:0] ETD_D_FRAG  = 32'h0000_0008;
  localparam logic [31:0] ETD_D_FSTEP = 32'h0000_0008;
  localparam logic [31:0] ETD_D_FLEN  = 32'h0000_0004;
  localparam logic [31:0] ETD_WORD    = 32'h0000_0004;
  localparam int ETD_C_DONE  = 31;
  localparam int ETD_C_IRQ   = 30;
  localparam int ETD_C_RND_LO = 16;
  localparam int ETD_C_NFRAG_W = 4;
  localparam logic [1:0] ETD_RND_WORD = 2'h0;
  // IP multicast destination prefix.
  localparam logic [23:0] ETD_IP_PREFIX = 24'h01005e;
  // Transmit buffer queue size in bytes and reset values.
  localparam int ETD_TXQ_BYTES = 2048;
  localparam logic [15:0] ETD_RELTH_RST = 16'h0080;
  // Pause slot time at each line rate.
  localparam int ETD_CLK_NS     = 40;
  localparam int ETD_SLOT10_NS  = 51200;
  localparam int ETD_SLOT100_NS = 5120;
  localparam int ETD_SLOT10_CYC  = (ETD_SLOT10_NS + ETD_CLK_NS - 1) / ETD_CLK_NS;
  localparam int ETD_SLOT100_CYC = (ETD_SLOT100_NS + ETD_CLK_NS - 1) / ETD_CLK_NS;
  typedef enum logic [3:0] {
    ETD_IDLE  = 4'b0000, ETD_RLINK = 4'b0001, ETD_RCTRL = 4'b0010,
    ETD_RFADR = 4'b0011, ETD_RFLEN = 4'b0100, ETD_MOVE  = 4'b0101,
    ETD_RCTL2 = 4'b0110, ETD_WDONE = 4'b0111, ETD_HOLD  = 4'b1000,
    ETD_PWAIT = 4'b1001
  } etd_state_t;
endpackage : etd_pkg

/* File: rtl/etd_rx_filter.sv */
// Receive destination address filter: own unicast, hashed group, IP group.
// Assumes the destination address arrives as a 48-bit word, first octet in bits 47:40.
`timescale 1ns/1ps
`default_nettype none
module etd_rx_filter
  import etd_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic [47:0] dest_i,
  input  wire logic        dest_valid_i,
  input  wire logic [47:0] node_addr_i,
  input  wire logic [63:0] group_hash_bits_i,
  input  wire logic [2:0]  rx_match_config_i,
  output logic             accept_o,
  output logic             accept_valid_o
);
  // Ethernet CRC over the six address octets, each octet sent low bit first.
  function automatic logic [31:0] addr_crc(input logic [47:0] a);
    logic [31:0] c;
    c = 32'hffff_ffff;
    for (int i = 0; i < 48; i++) begin
      c = (c[0] ^ a[47 - (i / 8) * 8 - 7 + (i % 8)]) ? ((c >> 1) ^ 32'hedb8_8320) : (c >> 1);
    end
    return c;
  endfunction

  logic        group;
  logic [31:0] crc;
  logic [5:0]  hidx;
  logic        hit_uni;
  logic        hit_hash;
  logic        hit_ip;
  assign group    = dest_i[40];
  assign crc      = addr_crc(dest_i);
  assign hidx     = crc[5:0];
  assign hit_uni  = rx_match_config_i[ETD_RX_UNI] && (dest_i == node_addr_i);
  assign hit_hash = rx_match_config_i[ETD_RX_HASH] && group && group_hash_bits_i[hidx];
  assign hit_ip   = rx_match_config_i[ETD_RX_IPG] && (dest_i[47:24] == ETD_IP_PREFIX);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      accept_o       <= 1'b0;
      accept_valid_o <= 1'b0;
    end else begin
      accept_valid_o <= dest_valid_i;
      accept_o       <= dest_valid_i && (hit_uni || hit_hash || hit_ip);
    end
  end

  ip_group_a: assert property (@(posedge clock_i) disable iff (srst_i)
    dest_valid_i && rx_match_config_i[ETD_RX_IPG] && dest_i[47:24] == ETD_IP_PREFIX
    |=> accept_o) else $error("IP group frame not accepted");
  own_uni_a: assert property (@(posedge clock_i) disable iff (srst_i)
    dest_valid_i && rx_match_config_i == 3'h1 && dest_i != node_addr_i |=> !accept_o)
    else $error("foreign unicast accepted");
endmodule // etd_rx_filter
`default_nettype wire

/* File: rtl/etd_tx_dma_mac.sv */
// Transmit descriptor engine, transmit queue accounting and MAC mode control.
// Assumes a single-word memory read/write port with ack and an APB register master.
// Function
// - Accept unicast equal to node address when own-unicast bit set.
// - Hashed group frames pass only if their 64-bit table bit is set.
// - IP group acceptance passes destinations starting 01005e.
// - Half duplex uses CSMA/CD and retransmits collided frames.
// - Full duplex ignores overlap; no collision handling.
// - With pause honour set, received pause suppresses data frame starts.
// - Pause unit is 51.2 us at 10 Mbps, 5.12 us at 100 Mbps.
// - Non-zero write to chain head while the engine is idle starts descriptor fetch.
// - Fragment address and length are read one at a time into registers.
// - Moving more than the queue holds flags overrun.
// - Zero chain head means nothing pending; no DMA.
// - Zero link returns engine to idle; otherwise follow link unless a refetch is pending or the head is written.
// - Non-zero poll interval re-reads last link until non-zero.
// - Done flag written into each descriptor after its frame moved.
// - Control word read before and after; done indication needs second read.
// - Frame length rounded to word or dword; x1 disables.
// - With transmit enabled, start once whole frame is resident.
// - Frame space freed only after transmitted bytes reach threshold.
// - Transmit queue holds 2K bytes.
// - Collision after release reports late fault and refetches frame, unless the engine has already followed a non-zero link.
`timescale 1ns/1ps
`default_nettype none
module etd_tx_dma_mac
  import etd_pkg::*;
#(
  parameter int TXQ_BYTES = etd_pkg::ETD_TXQ_BYTES
)(
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic [31:0]      mem_addr_o,
  output logic [31:0]      mem_wdata_o,
  input  wire logic        mem_ack_i,
  input  wire logic [31:0] mem_rdata_i,
  output logic [31:0]      txq_data_o,
  output logic             txq_valid_o,
  output logic             tx_start_o,
  output logic [15:0]      tx_frame_len_o,
  input  wire logic        tx_byte_i,
  input  wire logic        tx_end_i,
  input  wire logic        tx_collision_i,
  input  wire logic        speed_100_i,
  input  wire logic        rx_pause_i,
  input  wire logic [15:0] rx_pause_time_i,
  input  wire logic [47:0] rx_dest_i,
  input  wire logic        rx_dest_valid_i,
  output logic             rx_accept_o,
  output logic             rx_accept_valid_o,
  output logic             done_ind_o,
  output logic             duplex_full_en_o
);
  localparam logic [10:0] SLOT10  = 11'(ETD_SLOT10_CYC - 1);
  localparam logic [10:0] SLOT100 = 11'(ETD_SLOT100_CYC - 1);
  localparam logic [12:0] QCAP    = 13'(TXQ_BYTES);

  function automatic logic [15:0] round_len(input logic [15:0] n, input logic [1:0] sel);
    if (sel[0]) return n;
    if (sel == ETD_RND_WORD) return (n + 16'h1) & 16'hfffe;
    return (n + 16'h3) & 16'hfffc;
  endfunction

  etd_state_t  st_q;
  logic [31:0] head_q, poll_q, desc_q, ctrl_q, faddr_q, node_lo_q, hash_lo_q, hash_hi_q;
  logic [15:0] node_hi_q, relth_q, flen_q, frame_len_q, sent_q;
  logic [3:0]  mac_q;
  logic [2:0]  rxcfg_q;
  logic [3:0]  nfrag_q, fidx_q;
  logic [12:0] occ_q, fslot_q;
  logic        ovr_q, late_q, done_q, resident_q, sending_q, released_q, refetch_q;
  logic [31:0] pcnt_q;
  logic [15:0] punits_q;
  logic [10:0] pslot_q;
  logic        acc, wr, go_pulse, head_wr, last_word, push, release_now;
  logic [31:0] rdata;
  logic [12:0] occ_next;

  assign acc      = psel_i && penable_i && !pready_o;
  assign wr       = psel_i && penable_i && pready_o && pwrite_i;
  assign head_wr  = wr && paddr_i == ETD_OFS_HEAD;
  assign go_pulse = wr && paddr_i == ETD_OFS_MACCTL && pwdata_i[ETD_MC_GO];
  assign last_word = flen_q <= 16'(ETD_WORD);
  assign push     = st_q == ETD_MOVE && mem_req_o && mem_ack_i;
  assign release_now = sending_q && !released_q && sent_q >= relth_q;

  // APB slave: one wait state, read data and error registered with pready.
  always_comb begin
    rdata = 32'h0;
    case (paddr_i)
      ETD_OFS_HEAD:    rdata = head_q;
      ETD_OFS_POLL:    rdata = poll_q;
      ETD_OFS_MACCTL:  rdata = {29'h0, mac_q[2:0]};
      ETD_OFS_RXCFG:   rdata = {29'h0, rxcfg_q};
      ETD_OFS_NODE_LO: rdata = node_lo_q;
      ETD_OFS_NODE_HI: rdata = {16'h0, node_hi_q};
      ETD_OFS_HASH_LO: rdata = hash_lo_q;
      ETD_OFS_HASH_HI: rdata = hash_hi_q;
      ETD_OFS_RELTH:   rdata = {16'h0, relth_q};
      ETD_OFS_STATUS:  rdata = {27'h0, punits_q != 16'h0, st_q != ETD_IDLE, done_q, late_q, ovr_q};
      ETD_OFS_OCC:     rdata = {19'h0, occ_q};
      default:         rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= acc;
      prdata_o  <= acc ? rdata : 32'h0;
      pslverr_o <= acc && (paddr_i > ETD_OFS_OCC || paddr_i[1:0] != 2'h0);
    end
  end

  // Software configuration registers.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      poll_q <= 32'h0; mac_q <= 4'h0; rxcfg_q <= 3'h0; node_lo_q <= 32'h0;
      node_hi_q <= 16'h0; hash_lo_q <= 32'h0; hash_hi_q <= 32'h0; relth_q <= ETD_RELTH_RST;
    end else if (wr) begin
      case (paddr_i)
        ETD_OFS_POLL:    poll_q <= pwdata_i;
        ETD_OFS_MACCTL:  mac_q <= {1'b0, pwdata_i[2:0]};
        ETD_OFS_RXCFG:   rxcfg_q <= pwdata_i[2:0];
        ETD_OFS_NODE_LO: node_lo_q <= pwdata_i;
        ETD_OFS_NODE_HI: node_hi_q <= pwdata_i[15:0];
        ETD_OFS_HASH_LO: hash_lo_q <= pwdata_i;
        ETD_OFS_HASH_HI: hash_hi_q <= pwdata_i;
        ETD_OFS_RELTH:   relth_q <= pwdata_i[15:0];
        default: ;
      endcase
    end
  end
  assign duplex_full_en_o = mac_q[ETD_MC_DUPLEX];

  // Descriptor engine. The chain head tracks the descriptor being worked on.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      st_q <= ETD_IDLE; head_q <= 32'h0; desc_q <= 32'h0; ctrl_q <= 32'h0;
      faddr_q <= 32'h0; flen_q <= 16'h0; nfrag_q <= 4'h0; fidx_q <= 4'h0;
      frame_len_q <= 16'h0; mem_req_o <= 1'b0; mem_we_o <= 1'b0;
      mem_addr_o <= 32'h0; mem_wdata_o <= 32'h0; pcnt_q <= 32'h0;
    end else begin
      case (st_q)
        ETD_IDLE: begin
          if (head_wr) begin
            head_q <= pwdata_i;
            desc_q <= pwdata_i;
            if (pwdata_i != 32'h0) begin
              st_q <= ETD_HOLD;
            end
          end else if (head_q != 32'h0 && (go_pulse || refetch_q)) begin
            st_q <= ETD_HOLD;
          end else if (desc_q != 32'h0 && poll_q != 32'h0) begin
            pcnt_q <= poll_q;
            st_q   <= ETD_PWAIT;
          end
        end
        ETD_PWAIT: begin
          if (poll_q == 32'h0 || head_wr) begin
            st_q <= ETD_IDLE;
          end else if (pcnt_q <= 32'h1) begin
            mem_req_o <= 1'b1; mem_addr_o <= desc_q + ETD_D_LINK;
            st_q <= ETD_RLINK;
          end else begin
            pcnt_q <= pcnt_q - 32'h1;
          end
        end
        ETD_HOLD: begin
          // Waits until the previous frame has left the queue, or refetches it.
          if (!resident_q) begin
            mem_req_o <= 1'b1; mem_addr_o <= desc_q + ETD_D_CTRL;
            frame_len_q <= 16'h0; fidx_q <= 4'h0;
            st_q <= ETD_RCTRL;
          end
        end
        ETD_RCTRL: if (mem_ack_i) begin
          ctrl_q  <= mem_rdata_i;
          nfrag_q <= mem_rdata_i[ETD_C_NFRAG_W-1:0];
          mem_addr_o <= desc_q + ETD_D_FRAG;
          st_q <= ETD_RFADR;
        end
        ETD_RFADR: if (mem_ack_i) begin
          faddr_q <= mem_rdata_i;
          mem_addr_o <= mem_addr_o + ETD_D_FLEN;
          st_q <= ETD_RFLEN;
        end
        ETD_RFLEN: if (mem_ack_i) begin
          flen_q <= mem_rdata_i[15:0];
          frame_len_q <= frame_len_q + mem_rdata_i[15:0];
          mem_addr_o <= faddr_q;
          mem_req_o <= mem_rdata_i[15:0] != 16'h0;
          st_q <= ETD_MOVE;
        end
        ETD_MOVE: begin
          if (!mem_req_o || (mem_ack_i && last_word)) begin
            fidx_q <= fidx_q + 4'h1;
            mem_req_o <= 1'b1;
            if (fidx_q + 4'h1 < nfrag_q) begin
              mem_addr_o <= desc_q + ETD_D_FRAG + ETD_D_FSTEP * 32'(fidx_q + 4'h1);
              st_q <= ETD_RFADR;
            end else begin
              mem_addr_o <= desc_q + ETD_D_CTRL;
              st_q <= ETD_RCTL2;
            end
          end else if (mem_ack_i) begin
            flen_q <= flen_q - 16'(ETD_WORD);
            mem_addr_o <= mem_addr_o + ETD_WORD;
          end
        end
        ETD_RCTL2: if (mem_ack_i) begin
          ctrl_q <= mem_rdata_i;
          mem_we_o <= 1'b1;
          mem_wdata_o <= mem_rdata_i | (32'h1 << ETD_C_DONE);
          st_q <= ETD_WDONE;
        end
        ETD_WDONE: if (mem_ack_i) begin
          mem_we_o <= 1'b0;
          mem_addr_o <= desc_q + ETD_D_LINK;
          st_q <= ETD_RLINK;
        end
        ETD_RLINK: if (mem_ack_i) begin
          mem_req_o <= 1'b0;
          if (mem_rdata_i == 32'h0) begin
            st_q <= ETD_IDLE;
          end else if (refetch_q || head_wr) begin
            st_q <= ETD_IDLE;
          end else begin
            desc_q <= mem_rdata_i;
            head_q <= mem_rdata_i;
            st_q   <= ETD_HOLD;
          end
        end
        default: st_q <= ETD_IDLE;
      endcase
      if (st_q == ETD_RLINK && mem_ack_i && mem_rdata_i == 32'h0 && head_wr) begin
        head_q <= pwdata_i;
      end
    end
  end

  // Queue accounting: data slots are whole words, space is freed per frame.
  assign occ_next = occ_q + 13'(ETD_WORD);
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      occ_q <= 13'h0; fslot_q <= 13'h0; txq_valid_o <= 1'b0; txq_data_o <= 32'h0;
    end else begin
      txq_valid_o <= push && occ_next <= QCAP;
      txq_data_o  <= push ? mem_rdata_i : txq_data_o;
      if (release_now) begin
        occ_q   <= occ_q - fslot_q + ((push && occ_next <= QCAP) ? 13'(ETD_WORD) : 13'h0);
        fslot_q <= 13'h0;
      end else if (push && occ_next <= QCAP) begin
        occ_q   <= occ_next;
        fslot_q <= fslot_q + 13'(ETD_WORD);
      end
    end
  end

  // Sticky status flags; a new event wins over a clear in the same cycle.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ovr_q <= 1'b0; late_q <= 1'b0; done_q <= 1'b0; done_ind_o <= 1'b0;
    end else begin
      if (wr && paddr_i == ETD_OFS_STATUS) begin
        ovr_q  <= ovr_q && !pwdata_i[ETD_ST_OVR];
        late_q <= late_q && !pwdata_i[ETD_ST_LATE];
        done_q <= done_q && !pwdata_i[ETD_ST_DONE];
      end
      if (push && occ_next > QCAP) ovr_q <= 1'b1;
      if (sending_q && released_q && tx_collision_i && !mac_q[ETD_MC_DUPLEX]) late_q <= 1'b1;
      if (st_q == ETD_RCTL2 && mem_ack_i && mem_rdata_i[ETD_C_IRQ]) done_q <= 1'b1;
      done_ind_o <= done_q;
    end
  end

  // Transmit side: start on a resident frame, count bytes, handle collisions.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      resident_q <= 1'b0; sending_q <= 1'b0; released_q <= 1'b0; refetch_q <= 1'b0;
      sent_q <= 16'h0; tx_start_o <= 1'b0; tx_frame_len_o <= 16'h0;
    end else begin
      tx_start_o <= 1'b0;
      if (st_q == ETD_RCTL2 && mem_ack_i) begin
        resident_q <= 1'b1;
        refetch_q  <= 1'b0;
        tx_frame_len_o <= round_len(frame_len_q, ctrl_q[ETD_C_RND_LO +: 2]);
      end
      if (resident_q && !sending_q && !tx_start_o && mac_q[ETD_MC_TXEN]
          && punits_q == 16'h0 && st_q != ETD_RCTL2) begin
        tx_start_o <= 1'b1;
        sending_q  <= 1'b1;
        sent_q     <= 16'h0;
      end
      if (sending_q && tx_byte_i) sent_q <= sent_q + 16'h1;
      if (release_now) released_q <= 1'b1;
      if (sending_q && tx_collision_i && !mac_q[ETD_MC_DUPLEX]) begin
        sending_q <= 1'b0;
        if (released_q) begin
          resident_q <= 1'b0;
          released_q <= 1'b0;
          refetch_q  <= 1'b1;
        end
      end else if (sending_q && tx_end_i) begin
        sending_q  <= 1'b0;
        resident_q <= 1'b0;
        released_q <= 1'b0;
      end
    end
  end

  // Pause timer counting slot times at the current line rate.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      punits_q <= 16'h0; pslot_q <= 11'h0;
    end else if (rx_pause_i && mac_q[ETD_MC_PAUSE]) begin
      punits_q <= rx_pause_time_i;
      pslot_q  <= 11'h0;
    end else if (punits_q != 16'h0) begin
      if (pslot_q >= (speed_100_i ? SLOT100 : SLOT10)) begin
        pslot_q  <= 11'h0;
        punits_q <= punits_q - 16'h1;
      end else begin
        pslot_q <= pslot_q + 11'h1;
      end
    end
  end

  etd_rx_filter u_filter (
    .clock_i           (clock_i),
    .srst_i            (srst_i),
    .dest_i            (rx_dest_i),
    .dest_valid_i      (rx_dest_valid_i),
    .node_addr_i       ({node_hi_q, node_lo_q}),
    .group_hash_bits_i ({hash_hi_q, hash_lo_q}),
    .rx_match_config_i (rxcfg_q),
    .accept_o          (rx_accept_o),
    .accept_valid_o    (rx_accept_valid_o)
  );

  sequence head_go_s;
    st_q == ETD_IDLE && head_wr && pwdata_i != 32'h0;
  endsequence
  sequence ctrl_fetch_s;
    mem_req_o && !mem_we_o && mem_addr_o == desc_q + ETD_D_CTRL;
  endsequence

  head_start_a: assert property (@(posedge clock_i) disable iff (srst_i)
    head_go_s ##1 !resident_q |=> ctrl_fetch_s) else $error("no fetch after head write");
  zero_head_a: assert property (@(posedge clock_i) disable iff (srst_i)
    st_q == ETD_IDLE && head_wr && pwdata_i == 32'h0 |=> st_q == ETD_IDLE)
    else $error("DMA left idle on zero head");
  zero_link_a: assert property (@(posedge clock_i) disable iff (srst_i)
    st_q == ETD_RLINK && mem_ack_i && mem_rdata_i == 32'h0 |=> st_q == ETD_IDLE && !mem_req_o)
    else $error("engine not idle after zero link");
  done_write_a: assert property (@(posedge clock_i) disable iff (srst_i)
    st_q == ETD_WDONE |-> mem_we_o && mem_wdata_o[ETD_C_DONE] && mem_addr_o == desc_q + ETD_D_CTRL)
    else $error("done flag not written back");
  pause_block_a: assert property (@(posedge clock_i) disable iff (srst_i)
    punits_q != 16'h0 |-> ##1 !tx_start_o) else $error("frame started during pause");
  slot_len_a: assert property (@(posedge clock_i) disable iff (srst_i)
    $fell(punits_q == 16'h1) && !$past(rx_pause_i) |-> $past(pslot_q) == (speed_100_i ? SLOT100 : SLOT10))
    else $error("pause unit length wrong");
  overrun_a: assert property (@(posedge clock_i) disable iff (srst_i)
    push && occ_next > QCAP |=> ovr_q && !txq_valid_o) else $error("overrun not flagged");
  release_a: assert property (@(posedge clock_i) disable iff (srst_i)
    $fell(fslot_q != 13'h0) && !srst_i |-> $past(sent_q) >= $past(relth_q))
    else $error("space freed before threshold");
  start_res_a: assert property (@(posedge clock_i) disable iff (srst_i)
    tx_start_o |-> resident_q && mac_q[ETD_MC_TXEN]) else $error("start without frame");
endmodule // etd_tx_dma_mac
`default_nettype wire

/* File: tb/etd_mem_model.sv */
// Host memory holding descriptors and fragment data for the transfer engine.
// Assumes addresses below 1 KiB and one request at a time.
`timescale 1ns/1ps
`default_nettype none
module etd_mem_model (
  input  wire logic        clock_i,
  input  wire logic        mem_req_i,
  input  wire logic        mem_we_i,
  input  wire logic [31:0] mem_addr_i,
  input  wire logic [31:0] mem_wdata_i,
  output logic             mem_ack_o = 1'b0,
  output logic [31:0]      mem_rdata_o = 32'h0
);
  logic [31:0] mem_q [256];
  int          wait_q = 0;
  // Read data outside the answer cycle toggles so that stale data is never trusted.
  always @(posedge clock_i) begin
    mem_ack_o   <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o;
    if (mem_req_i && !mem_ack_o) begin
      if (wait_q == 0) begin
        mem_ack_o   <= 1'b1;
        mem_rdata_o <= mem_q[mem_addr_i[9:2]];
        if (mem_we_i)
          mem_q[mem_addr_i[9:2]] <= mem_wdata_i;
        wait_q <= $urandom_range(3);
      end else
        wait_q <= wait_q - 1;
    end
  end
endmodule // etd_mem_model
`default_nettype wire

/* File: tb/test_etd_tx_dma_mac.sv */
// Bench for etd_tx_dma_mac: registers, receive filter and descriptor transfers.
// Assumes etd_mem_model stands in for host memory.
`timescale 1ns/1ps
`default_nettype none
module test_etd_tx_dma_mac;
  import etd_pkg::*;
  logic        clock_i = 0, srst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, e, irq1;
  logic        tx_byte_i = 0, tx_end_i = 0, rx_dest_valid_i = 0, mem_ack_i;
  logic        tx_collision_i = 0, speed_100_i = 1, rx_pause_i = 0;
  logic [63:0] h;
  logic [7:0]  paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i, txq_data_o, r, c;
  logic [47:0] rx_dest_i = 0, node, d;
  logic [15:0] tx_frame_len_o, rx_pause_time_i = 0;
  logic        pready_o, pslverr_o, mem_req_o, mem_we_o, txq_valid_o, tx_start_o;
  logic        rx_accept_o, rx_accept_valid_o, done_ind_o, duplex_full_en_o;
  int          n_fail = 0, n_tests = 0, n, w, len, sl;
  etd_tx_dma_mac dut (.clock_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o,
    .mem_ack_i, .mem_rdata_i, .txq_data_o, .txq_valid_o, .tx_start_o, .tx_frame_len_o,
    .tx_byte_i, .tx_end_i, .tx_collision_i, .speed_100_i, .rx_pause_i,
    .rx_pause_time_i, .rx_dest_i, .rx_dest_valid_i, .rx_accept_o,
    .rx_accept_valid_o, .done_ind_o, .duplex_full_en_o);
  etd_mem_model mdl (.clock_i, .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
    .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i),
    .mem_rdata_o(mem_rdata_i));
  initial forever #20 clock_i = ~clock_i;
  function automatic logic [15:0] rnd_len(input int l, input logic [1:0] s);
    if (s[0]) return 16'(l);
    if (s[1]) return 16'((l + 3) & ~3);
    return 16'((l + 1) & ~1);
  endfunction
  // Group hash index: low six bits of the reflected CRC, octets sent low bit first.
  function automatic logic [5:0] hash_idx(input logic [47:0] a);
    logic [31:0] q;
    q = 32'hffff_ffff;
    for (int i = 0; i < 48; i++)
      q = (q[0] ^ a[40 - 8 * (i / 8) + i % 8]) ? (q >> 1) ^ 32'hedb8_8320 : q >> 1;
    return q[5:0];
  endfunction
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    psel_i <= 1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clock_i);
    penable_i <= 1;
    do begin
      @(posedge clock_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    @(posedge clock_i);
  endtask
  task automatic give_verdict;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock_i);
    n_fail++;
    give_verdict;
  end
  initial begin
    void'($urandom(73591));
    repeat (6) @(posedge clock_i);
    srst_i <= 0;
    @(posedge clock_i);
    apb(0, ETD_OFS_RELTH, 0);
    chk(r, 32'h80);
    apb(1, ETD_OFS_RELTH, 8);
    apb(0, 8'hfc, 0);
    chk({r, e}, 33'h1);
    apb(1, ETD_OFS_MACCTL, 32'h7);
    chk(duplex_full_en_o, 1);
    apb(1, ETD_OFS_HEAD, 0);
    n = 0;
    repeat (20) begin
      @(posedge clock_i);
      if (mem_req_o !== 1'b0) n++;
    end
    chk(n, 0);
    node = 48'({$urandom, $urandom}) & ~48'h0100_0000_0000;
    apb(1, ETD_OFS_NODE_LO, node[31:0]);
    apb(1, ETD_OFS_NODE_HI, {16'h0, node[47:32]});
    h = {$urandom, $urandom};
    apb(1, ETD_OFS_HASH_LO, h[31:0]);
    apb(1, ETD_OFS_HASH_HI, h[63:32]);
    repeat (30) begin
      c = $urandom & 7;
      apb(1, ETD_OFS_RXCFG, c);
      n = $urandom % 3;
      d = n == 0 ? node : n == 1 ? {ETD_IP_PREFIX, 24'($urandom)} : 48'({$urandom, $urandom});
      rx_dest_i <= d;
      rx_dest_valid_i <= 1;
      @(posedge clock_i);
      rx_dest_valid_i <= 0;
      @(posedge clock_i);
      chk({rx_accept_valid_o, rx_accept_o}, {1'b1, c[0] && d == node
          || c[1] && d[40] && h[hash_idx(d)]
          || c[2] && d[47:24] == ETD_IP_PREFIX});
    end
    for (int f = 0; f < 4; f++) begin
      len = 8 + $urandom % 33;
      c = {1'b0, 1'($urandom), 12'h0, 2'(f), 12'h0, 4'h1};
      irq1 = 1'($urandom);
      mdl.mem_q[16] = 0;
      mdl.mem_q[17] = c;
      mdl.mem_q[18] = 32'h100;
      mdl.mem_q[19] = len;
      for (int i = 0; i < 12; i++) mdl.mem_q[64 + i] = $urandom;
      if (f[0]) begin
        speed_100_i <= f == 1;
        rx_pause_i <= 1;
        rx_pause_time_i <= 16'h1;
        @(posedge clock_i);
        rx_pause_i <= 0;
      end
      apb(1, ETD_OFS_HEAD, 32'h40);
      n = 0;
      w = 0;
      while (tx_start_o !== 1'b1 && n < 2000) begin
        @(posedge clock_i);
        n++;
        if (mem_req_o === 1'b1 && mem_addr_o === 32'h4c) mdl.mem_q[17][30] = irq1;
        if (txq_valid_o === 1'b1) begin
          chk(txq_data_o, mdl.mem_q[64 + w]);
          w++;
        end
      end
      chk(w, (len + 3) / 4);
      chk(tx_frame_len_o, rnd_len(len, c[17:16]));
      sl = f == 1 ? ETD_SLOT100_CYC : ETD_SLOT10_CYC;
      if (f[0]) chk(n > sl - 4 && n <= sl, 1);
      apb(0, ETD_OFS_OCC, 0);
      chk(r, 4 * w);
      if (f[0] == 0) begin
        apb(1, ETD_OFS_MACCTL, f == 2 ? 32'h6 : 32'h7);
        tx_collision_i <= 1;
        @(posedge clock_i);
        tx_collision_i <= 0;
        n = 0;
        while (tx_start_o !== 1'b1 && n < 20) begin
          @(posedge clock_i);
          n++;
        end
        chk(n < 20, f == 2);
        apb(1, ETD_OFS_MACCTL, 32'h7);
      end
      repeat (len) begin
        tx_byte_i <= 1;
        @(posedge clock_i);
        tx_byte_i <= 0;
        @(posedge clock_i);
      end
      tx_end_i <= 1;
      @(posedge clock_i);
      tx_end_i <= 0;
      n = 0;
      while (mdl.mem_q[17][31] !== 1'b1 && n < 200) begin
        @(posedge clock_i);
        n++;
      end
      repeat (10) @(posedge clock_i);
      chk(mdl.mem_q[17][31], 1);
      chk(done_ind_o, irq1);
      apb(0, ETD_OFS_OCC, 0);
      chk(r, 0);
      apb(0, ETD_OFS_STATUS, 0);
      chk(r[ETD_ST_BUSY], 0);
      apb(1, ETD_OFS_STATUS, 32'h7);
    end
    mdl.mem_q[32] = 0;
    mdl.mem_q[33] = 32'h1;
    mdl.mem_q[34] = 32'h100;
    mdl.mem_q[35] = 32'h5;
    mdl.mem_q[16] = 32'h80;
    apb(1, ETD_OFS_POLL, 32'h10);
    n = 0;
    while (tx_start_o !== 1'b1 && n < 500) begin
      @(posedge clock_i);
      n++;
    end
    chk(tx_frame_len_o, 16'h6);
    give_verdict;
  end
endmodule // test_etd_tx_dma_mac
`default_nettype wire
